// *** dsf_ctrl_sink.sv ***
// Controller-side byte sink that can stall
`timescale 1ns/1ps
module dsf_ctrl_sink (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic stall,
    input  wire logic outValid,
    output logic      outReady
);
    logic [1:0] phase_q;

    // Stall pattern: takes one byte in three, whole field incl. check bytes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_q <= 2'h0;
        end else if (outValid) begin
            phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
        end
    end
    assign outReady = !stall || (phase_q == 2'h0);
endmodule // dsf_ctrl_sink

// *** dsf_defect_sector_gen.sv ***
// Defect-list sector data generator with write splice timing
`timescale 1ns/1ps
`include "dsf_defs.svh"
module dsf_defect_sector_gen #(
    parameter int          ENTRIES      = 8,
    parameter int          SECTOR_BYTES = `DSF_SECTOR_BYTES,
    parameter logic [9:0]  MAX_CYL      = 10'h3ff,
    parameter logic [63:0] MODEL_NAME   = 64'h4d4f44454c2d3031, // Arbitrary
    parameter logic [55:0] SERIAL_NUM   = 56'h30303030303031    // Arbitrary
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        entClear,
    input  wire logic                        entWe,
    output logic                             entReady,
    input  wire dsf_pkg::dsf_entry_t         entData,
    output logic [$clog2(ENTRIES+1)-1:0]     defectCount,
    input  wire logic                        reqValid,
    output logic                             reqReady,
    input  wire logic [9:0]                  reqCyl,
    input  wire logic [2:0]                  reqHead,
    input  wire logic [7:0]                  reqSector,
    output logic                             outValid,
    input  wire logic                        outReady,
    output logic [7:0]                       outData,
    output logic                             outLast,
    input  wire logic                        writeGatePin,
    output logic                             writeDriverOn
);
    localparam int CW = $clog2(ENTRIES+1);
    localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
    localparam int SPLICE_CYCLES = `DSF_SPLICE_CYCLES;

    dsf_stream_if genS ();

    //////////////////////////////////////////////////////////////////////
    // Defect table

    dsf_pkg::dsf_entry_t tblQ [ENTRIES];
    dsf_pkg::dsf_entry_t tblD [ENTRIES];
    logic [CW-1:0]       cntQ, cntD;
    dsf_pkg::dsf_state_t stQ, stD;

    assign entReady    = (stQ == dsf_pkg::ST_IDLE) && (cntQ != CW'(ENTRIES));
    assign defectCount = cntQ;

    // Append or clear only while no sector is being built
    always_comb begin
        tblD = tblQ;
        cntD = cntQ;
        if (stQ == dsf_pkg::ST_IDLE) begin
            if (entClear) begin
                cntD = '0;
            end else if (entWe && entReady) begin
                tblD[cntQ[IW-1:0]] = entData;
                cntD = cntQ + CW'(1);
            end
        end
    end

    // Table registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < ENTRIES; i++) begin
                tblQ[i] <= '0;
            end
            cntQ <= '0;
        end else begin
            tblQ <= tblD;
            cntQ <= cntD;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Sector byte generator

    dsf_pkg::dsf_kind_t  kindQ, kindD;
    logic [2:0]          headQ, headD;
    logic [8:0]          byteQ, byteD;
    logic [CW-1:0]       ptrQ, ptrD;
    logic [2:0]          subQ, subD;
    logic [15:0]         crcQ, crcD;
    logic [7:0]          curByte;
    logic                skip;
    logic                recByte;
    dsf_pkg::dsf_entry_t cur;
    dsf_pkg::dsf_kind_t  reqKind;

    // MSB-first CRC over one byte
    function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ `DSF_CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction

    assign cur = tblQ[ptrQ[IW-1:0]];

    // Classify requested sector
    always_comb begin
        reqKind = dsf_pkg::KIND_NONE;
        if (reqSector == 8'h00 && (reqCyl == MAX_CYL ||
            reqCyl == MAX_CYL - `DSF_ESDI_MIRROR_DIST)) begin
            reqKind = dsf_pkg::KIND_ESDI;
        end else if (reqCyl == 10'h000 && reqSector <= `DSF_OPT_LAST_SECTOR) begin
            reqKind = dsf_pkg::KIND_OPT;
        end
    end

    // Data byte for the current position
    always_comb begin
        curByte = `DSF_PAD_BYTE;
        skip    = 1'b0;
        recByte = 1'b0;
        if (kindQ == dsf_pkg::KIND_ESDI) begin
            if (ptrQ < cntQ) begin
                if (subQ == 3'h0 && cur.head != headQ) begin
                    skip = 1'b1; // Other surface's entry
                end else begin
                    recByte = 1'b1;
                    case (subQ)
                        3'h0: curByte = {6'h00, cur.cyl[9:8]};
                        3'h1: curByte = cur.cyl[7:0];
                        3'h2: curByte = cur.pos[15:8];
                        3'h3: curByte = cur.pos[7:0];
                        default: curByte = cur.len;
                    endcase
                end
            end else begin
                curByte = `DSF_FILL_BYTE;
            end
        end else if (kindQ == dsf_pkg::KIND_OPT) begin
            if (byteQ <= `DSF_OPT_MODEL_LAST) begin
                curByte = MODEL_NAME[8*(7-int'(byteQ - `DSF_OPT_MODEL_FIRST)) +: 8];
            end else if (byteQ <= `DSF_OPT_SERIAL_LAST) begin
                curByte = SERIAL_NUM[8*(6-int'(byteQ - `DSF_OPT_SERIAL_FIRST)) +: 8];
            end else if (byteQ == `DSF_OPT_ZERO_BYTE) begin
                curByte = `DSF_PAD_BYTE;
            end else if (byteQ < `DSF_OPT_COUNT_LOW) begin
                curByte = `DSF_PAD_BYTE;
            end else if (byteQ == `DSF_OPT_COUNT_LOW) begin
                curByte = 8'(cntQ);
            end else if (ptrQ < cntQ) begin
                recByte = 1'b1;
                case (subQ)
                    3'h0: curByte = {6'h00, cur.cyl[9:8]};
                    3'h1: curByte = cur.cyl[7:0];
                    3'h2: curByte = {5'h00, cur.head};
                    3'h3: curByte = cur.sector;
                    3'h4: curByte = cur.pos[15:8];
                    3'h5: curByte = cur.pos[7:0];
                    3'h6: curByte = cur.len;
                    default: curByte = `DSF_PAD_BYTE;
                endcase
            end else begin
                curByte = `DSF_FILL_BYTE;
            end
        end
    end

    assign reqReady   = (stQ == dsf_pkg::ST_IDLE) && !entWe && !entClear;
    assign genS.valid = ((stQ == dsf_pkg::ST_DATA) && !skip) ||
                        (stQ == dsf_pkg::ST_CRCH) || (stQ == dsf_pkg::ST_CRCL);
    assign genS.last  = (stQ == dsf_pkg::ST_CRCL);

    // Byte to the FIFO, check bytes high first
    always_comb begin
        genS.data = curByte;
        if (stQ == dsf_pkg::ST_CRCH) begin
            genS.data = crcQ[15:8];
        end else if (stQ == dsf_pkg::ST_CRCL) begin
            genS.data = crcQ[7:0];
        end
    end

    // Sequencing of one data field
    always_comb begin
        stD   = stQ;
        kindD = kindQ;
        headD = headQ;
        byteD = byteQ;
        ptrD  = ptrQ;
        subD  = subQ;
        crcD  = crcQ;
        case (stQ)
            dsf_pkg::ST_IDLE: begin
                if (reqValid && reqReady) begin
                    stD   = dsf_pkg::ST_DATA;
                    kindD = reqKind;
                    headD = reqHead;
                    byteD = '0;
                    ptrD  = '0;
                    subD  = '0;
                    crcD  = `DSF_CRC_INIT;
                end
            end
            dsf_pkg::ST_DATA: begin
                if (skip) begin
                    ptrD = ptrQ + CW'(1);
                end else if (genS.ready) begin
                    crcD = crcByte(crcQ, curByte);
                    if (recByte) begin
                        if (subQ == ((kindQ == dsf_pkg::KIND_ESDI) ?
                                     `DSF_ESDI_ENTRY_LAST : `DSF_OPT_RECORD_LAST)) begin
                            subD = '0;
                            ptrD = ptrQ + CW'(1);
                        end else begin
                            subD = subQ + 3'h1;
                        end
                    end
                    if (byteQ == 9'(SECTOR_BYTES-1)) begin
                        stD = dsf_pkg::ST_CRCH; // End of sector ends the list
                    end else begin
                        byteD = byteQ + 9'h001;
                    end
                end
            end
            dsf_pkg::ST_CRCH: begin
                if (genS.ready) begin
                    stD = dsf_pkg::ST_CRCL;
                end
            end
            dsf_pkg::ST_CRCL: begin
                if (genS.ready) begin
                    stD = dsf_pkg::ST_IDLE;
                end
            end
            default: stD = dsf_pkg::ST_IDLE;
        endcase
    end

    // Generator registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stQ   <= dsf_pkg::ST_IDLE;
            kindQ <= dsf_pkg::KIND_NONE;
            headQ <= '0;
            byteQ <= '0;
            ptrQ  <= '0;
            subQ  <= '0;
            crcQ  <= `DSF_CRC_INIT;
        end else begin
            stQ   <= stD;
            kindQ <= kindD;
            headQ <= headD;
            byteQ <= byteD;
            ptrQ  <= ptrD;
            subQ  <= subD;
            crcQ  <= crcD;
        end
    end

    // Output buffer
    dsf_fifo #(
        .WIDTH (9),
        .DEPTH (`DSF_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .inS      (genS),
        .outValid (outValid),
        .outReady (outReady),
        .outData  (outData),
        .outLast  (outLast)
    );

    //////////////////////////////////////////////////////////////////////
    // Write driver turn-on after write gate

    logic [2:0] syncQ, syncD;
    logic       gateQ, gateD;
    logic [7:0] splQ, splD;
    logic       onQ, onD;

    assign writeDriverOn = onQ;

    // Filtered gate and splice timer
    always_comb begin
        syncD = {syncQ[1:0], writeGatePin};
        gateD = (syncQ[1] == syncQ[2]) ? syncQ[2] : gateQ;
        splD  = splQ;
        onD   = onQ;
        if (!gateQ) begin
            splD = '0;
            onD  = 1'b0;
        end else if (splQ == 8'(SPLICE_CYCLES - 1)) begin
            onD = 1'b1;
        end else begin
            splD = splQ + 8'h01;
        end
    end

    // Gate registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncQ <= '0;
            gateQ <= 1'b0;
            splQ  <= '0;
            onQ   <= 1'b0;
        end else begin
            syncQ <= syncD;
            gateQ <= gateD;
            splQ  <= splD;
            onQ   <= onD;
        end
    end
endmodule // dsf_defect_sector_gen

// *** dsf_defect_sector_gen_bench.sv ***
// Self-checking bench for the defect-list sector generator
`timescale 1ns/1ps
module dsf_defect_sector_gen_bench;
    localparam int          ENT    = 8;
    localparam logic [9:0]  TOPCYL = 10'h3ff;
    localparam logic [63:0] MODEL  = 64'h4d4f44454c2d3031; // Arbitrary text
    localparam logic [55:0] SERIAL = 56'h30303030303031;   // Arbitrary text

    logic                sys_clk, rst, entClear, entWe, entReady, stall;
    logic                reqValid, reqReady, outValid, outReady, outLast;
    logic                writeGatePin, writeDriverOn;
    dsf_pkg::dsf_entry_t entData;
    logic [3:0]          defectCount;
    logic [9:0]          reqCyl;
    logic [2:0]          reqHead;
    logic [7:0]          reqSector, outData;
    logic [7:0]          expB [258];
    int                  errors, samples_checked, nLoad;

    dsf_defect_sector_gen #(.ENTRIES(ENT), .MAX_CYL(TOPCYL), .MODEL_NAME(MODEL),
        .SERIAL_NUM(SERIAL)) dut (
        .sys_clk(sys_clk), .rst(rst), .entClear(entClear), .entWe(entWe),
        .entReady(entReady), .entData(entData), .defectCount(defectCount),
        .reqValid(reqValid), .reqReady(reqReady), .reqCyl(reqCyl), .reqHead(reqHead),
        .reqSector(reqSector), .outValid(outValid), .outReady(outReady),
        .outData(outData), .outLast(outLast), .writeGatePin(writeGatePin),
        .writeDriverOn(writeDriverOn));
    dsf_ctrl_sink sink (.sys_clk(sys_clk), .rst(rst), .stall(stall),
        .outValid(outValid), .outReady(outReady));

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic dsf_pkg::dsf_entry_t mk(int i);
        mk.cyl    = 10'(240 + i * 85);
        mk.head   = 3'(i % 3);
        mk.sector = 8'(i);
        mk.pos    = 16'(256 * i + 1);
        mk.len    = 8'(i + 1);
    endfunction

    function automatic logic [15:0] crc(logic [15:0] c, logic [7:0] b);
        c = c ^ {b, 8'h00};
        for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
        return c;
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Expected field: 0 zeros, 1 surface list, 2 bad-spot list
    task automatic build(input int kind, input logic [2:0] h);
        int p;
        logic [15:0] c;
        dsf_pkg::dsf_entry_t e;
        p = (kind == 2) ? 24 : 0;
        c = 16'h0000;
        for (int i = 0; i < 256; i++) expB[i] = (kind == 0) ? 8'h00 : 8'hff;
        if (kind == 2) begin
            for (int i = 0; i < 8; i++) expB[i] = MODEL[63-8*i -: 8];
            for (int i = 0; i < 7; i++) expB[8+i] = SERIAL[55-8*i -: 8];
            for (int i = 15; i < 23; i++) expB[i] = 8'h00;
            expB[23] = 8'(nLoad);
        end
        for (int i = 0; i < nLoad; i++) begin
            e = mk(i);
            if (kind == 2) begin
                {expB[p], expB[p+1], expB[p+2], expB[p+3], expB[p+4], expB[p+5], expB[p+6],
                 expB[p+7]} = {6'h00, e.cyl, 5'h00, e.head, e.sector, e.pos, e.len, 8'h00};
                p += 8;
            end else if (kind == 1 && e.head == h) begin
                {expB[p], expB[p+1], expB[p+2], expB[p+3], expB[p+4]} =
                    {6'h00, e.cyl, e.pos, e.len};
                p += 5;
            end
        end
        for (int i = 0; i < 256; i++) c = crc(c, expB[i]);
        expB[256] = c[15:8];
        expB[257] = c[7:0];
    endtask

    // Requests one field, pokes a table write while busy, compares all bytes
    task automatic fetch(input logic [9:0] cy, input logic [2:0] hd, input logic [7:0] sc);
        int n;
        int w;
        n = 0;
        w = 0;
        repeat (4000) @(posedge sys_clk);
        reqValid <= 1'b1;
        reqCyl <= cy;
        reqHead <= hd;
        reqSector <= sc;
        @(negedge sys_clk);
        chk(reqReady, 1'b1);
        @(posedge sys_clk);
        reqValid <= 1'b0;
        entWe <= 1'b1;
        entData <= mk(0);
        @(negedge sys_clk);
        chk({reqReady, entReady}, 2'b00);
        @(posedge sys_clk);
        entWe <= 1'b0;
        while (n < 258 && w < 4000) begin
            @(negedge sys_clk);
            w++;
            if (outValid === 1'b1 && outReady === 1'b1) begin
                chk(outData, expB[n]);
                chk(outLast, 16'(n == 257));
                n++;
            end
        end
        chk(defectCount, nLoad);
        if (w >= 4000) begin
            errors++;
            close_out();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_zero();
        chk({defectCount, outValid, writeDriverOn, entReady}, 7'h01);
        build(0, 3'h0);
        fetch(10'h005, 3'h0, 8'h03);
        build(0, 3'h0);
        fetch(10'h000, 3'h1, 8'h06);
        $display("test zero field done");
    endtask

    task automatic t_load();
        @(posedge sys_clk);
        entClear <= 1'b1;
        @(posedge sys_clk);
        entClear <= 1'b0;
        entWe <= 1'b1;
        for (int i = 0; i <= ENT; i++) begin
            entData <= mk(i);
            @(posedge sys_clk);
        end
        entWe <= 1'b0;
        nLoad = ENT;
        @(negedge sys_clk);
        chk(defectCount, ENT);
        chk(entReady, 1'b0);
        $display("test load done");
    endtask

    task automatic t_lists();
        stall <= 1'b1;
        build(1, 3'h1);
        fetch(TOPCYL, 3'h1, 8'h00);
        build(1, 3'h0);
        fetch(TOPCYL - 10'h008, 3'h0, 8'h00);
        build(2, 3'h0);
        fetch(10'h000, 3'h2, 8'h00);
        stall <= 1'b0;
        fetch(10'h000, 3'h7, 8'h05);
        $display("test lists done");
    endtask

    task automatic t_gate();
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        repeat (100) @(posedge sys_clk);
        writeGatePin <= 1'b1;
        repeat (100) begin
            @(negedge sys_clk);
            seen = seen | writeDriverOn;
        end
        @(posedge sys_clk);
        writeGatePin <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk(seen, 1'b0);
        writeGatePin <= 1'b1;
        while (writeDriverOn !== 1'b1 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        chk(16'(n >= 158 && n <= 167), 16'h1);
        if (n >= 300) begin
            errors++;
            close_out();
        end
        repeat (8) @(posedge sys_clk);
        writeGatePin <= 1'b0;
        repeat (9) @(posedge sys_clk);
        chk(writeDriverOn, 1'b0);
        $display("test write gate done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial begin
        {rst, entClear, entWe, reqValid, stall, writeGatePin} = 6'h20;
        entData = '0;
        {reqCyl, reqHead, reqSector} = '0;
        {errors, samples_checked, nLoad} = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        t_zero();
        t_load();
        t_lists();
        t_gate();
        close_out();
    end
endmodule // dsf_defect_sector_gen_bench

bind dsf_defect_sector_gen dsf_defect_sector_gen_chk #(.ENTRIES(ENTRIES)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .entClear(entClear), .entWe(entWe),
    .entReady(entReady), .entData(entData), .defectCount(defectCount),
    .reqValid(reqValid), .reqReady(reqReady), .reqCyl(reqCyl), .reqHead(reqHead),
    .reqSector(reqSector), .outValid(outValid), .outReady(outReady),
    .outData(outData), .outLast(outLast), .writeGatePin(writeGatePin),
    .writeDriverOn(writeDriverOn));

// *** dsf_defect_sector_gen_chk.sv ***
// Port-level checks for the defect-list sector generator
`timescale 1ns/1ps
`include "dsf_defs.svh"
module dsf_defect_sector_gen_chk #(
    parameter int ENTRIES = 8
) (
    input wire logic                         sys_clk,
    input wire logic                         rst,
    input wire logic                         entClear,
    input wire logic                         entWe,
    input wire logic                         entReady,
    input wire dsf_pkg::dsf_entry_t          entData,
    input wire logic [$clog2(ENTRIES+1)-1:0] defectCount,
    input wire logic                         reqValid,
    input wire logic                         reqReady,
    input wire logic [9:0]                   reqCyl,
    input wire logic [2:0]                   reqHead,
    input wire logic [7:0]                   reqSector,
    input wire logic                         outValid,
    input wire logic                         outReady,
    input wire logic [7:0]                   outData,
    input wire logic                         outLast,
    input wire logic                         writeGatePin,
    input wire logic                         writeDriverOn
);
    localparam int SPL = `DSF_SPLICE_CYCLES;
    logic [7:0] gateCnt_q;
    logic [8:0] popCnt_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Gate-high cycle count and bytes popped in the current field
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gateCnt_q <= 8'h00;
            popCnt_q  <= 9'h000;
        end else begin
            gateCnt_q <= !writeGatePin ? 8'h00 : gateCnt_q + {7'h00, gateCnt_q != 8'hff};
            popCnt_q  <= !(outValid && outReady) ? popCnt_q :
                         outLast ? 9'h000 : popCnt_q + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Named steps
    sequence reqTake;
        reqValid && reqReady;
    endsequence
    sequence entTake;
        entWe && entReady && !entClear;
    endsequence
    sequence popLast;
        outValid && outReady && outLast;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    out_hold_a: assert property (
        outValid && !outReady |=> outValid && $stable(outData) && $stable(outLast))
        else $error("output byte changed while stalled");
    field_len_a: assert property (
        popLast |-> popCnt_q == 9'd257)
        else $error("field length is not 258 bytes");
    count_inc_a: assert property (
        entTake |=> defectCount == $past(defectCount) + 1'b1)
        else $error("defect count did not step");
    clear_zero_a: assert property (
        entClear && entReady |=> defectCount == '0)
        else $error("clear left entries");
    full_block_a: assert property (
        int'(defectCount) == ENTRIES |-> !entReady)
        else $error("full table still accepts");
    busy_block_a: assert property (
        reqTake |=> !reqReady && !entReady)
        else $error("request accepted while busy");
    quiet_req_a: assert property (
        reqReady |-> !entWe && !entClear)
        else $error("request ready during table load");
    first_byte_a: assert property (
        reqTake ##0 !outValid |=> !outValid)
        else $error("byte appeared too early");
    splice_on_a: assert property (
        $rose(writeDriverOn) |-> gateCnt_q >= SPL && gateCnt_q <= SPL + 6)
        else $error("driver on outside splice time");
    splice_bound_a: assert property (
        gateCnt_q == SPL + 8 |-> writeDriverOn)
        else $error("driver late after gate");
    driver_off_a: assert property (
        $fell(writeGatePin) |-> ##[1:8] !writeDriverOn)
        else $error("driver stays on after gate");
endmodule // dsf_defect_sector_gen_chk

// *** dsf_defs.svh ***
// Constants for the defect-list sector generator
`ifndef DSF_DEFS_SVH
`define DSF_DEFS_SVH

`define DSF_SECTOR_BYTES      256
`define DSF_ESDI_MIRROR_DIST  10'h008
`define DSF_ESDI_ENTRY_LAST   3'h4
`define DSF_OPT_RECORD_LAST   3'h7
`define DSF_OPT_LAST_SECTOR   8'h05
`define DSF_OPT_MODEL_LAST    9'h007
`define DSF_OPT_SERIAL_LAST   9'h00e
`define DSF_OPT_ZERO_BYTE     9'h00f
`define DSF_OPT_COUNT_LOW     9'h017
`define DSF_OPT_RECORD_BASE   9'h018
`define DSF_OPT_MODEL_FIRST   9'h000
`define DSF_OPT_SERIAL_FIRST  9'h008
`define DSF_FILL_BYTE         8'hff
`define DSF_PAD_BYTE          8'h00
`define DSF_CRC_POLY          16'h1021
`define DSF_CRC_INIT          16'h0000
`define DSF_SPLICE_NS         800
`define DSF_CLK_MHZ           200
`define DSF_SPLICE_CYCLES     ((`DSF_SPLICE_NS * `DSF_CLK_MHZ + 999) / 1000)
`define DSF_FIFO_DEPTH        4

`endif

// *** dsf_fifo.sv ***
// Small flip-flop FIFO for the sector byte stream
`timescale 1ns/1ps
`include "dsf_defs.svh"
module dsf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = `DSF_FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    dsf_stream_if.snk             inS,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-2:0]      outData,
    output logic                  outLast
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] memQ [DEPTH];
    logic [WIDTH-1:0] memD [DEPTH];
    logic [AW-1:0]    wrQ, wrD, rdQ, rdD;
    logic [AW:0]      lvlQ, lvlD;
    logic             doWr, doRd;

    // Honest full and empty from the fill level
    assign inS.ready = (lvlQ != (AW+1)'(DEPTH));
    assign outValid  = (lvlQ != '0);
    assign doWr      = inS.valid && inS.ready;
    assign doRd      = outValid && outReady;
    assign outData   = memQ[rdQ][WIDTH-2:0];
    assign outLast   = memQ[rdQ][WIDTH-1];

    // Pointer and storage next values
    always_comb begin
        memD = memQ;
        wrD  = wrQ;
        rdD  = rdQ;
        lvlD = lvlQ;
        if (doWr) begin
            memD[wrQ] = {inS.last, inS.data};
            wrD = (wrQ == AW'(DEPTH-1)) ? '0 : wrQ + AW'(1);
        end
        if (doRd) begin
            rdD = (rdQ == AW'(DEPTH-1)) ? '0 : rdQ + AW'(1);
        end
        if (doWr && !doRd) begin
            lvlD = lvlQ + (AW+1)'(1);
        end else if (doRd && !doWr) begin
            lvlD = lvlQ - (AW+1)'(1);
        end
    end

    // Register stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                memQ[i] <= '0;
            end
            wrQ  <= '0;
            rdQ  <= '0;
            lvlQ <= '0;
        end else begin
            memQ <= memD;
            wrQ  <= wrD;
            rdQ  <= rdD;
            lvlQ <= lvlD;
        end
    end
endmodule // dsf_fifo

// *** dsf_pkg.sv ***
// Types shared by the defect-list sector generator
package dsf_pkg;

    // One logged defect
    typedef struct packed {
        logic [9:0]  cyl;
        logic [2:0]  head;
        logic [7:0]  sector;
        logic [15:0] pos;
        logic [7:0]  len;
    } dsf_entry_t;

    // Which list layout a requested sector carries
    typedef enum logic [2:0] {
        KIND_NONE = 3'b001,
        KIND_ESDI = 3'b010,
        KIND_OPT  = 3'b100
    } dsf_kind_t;

    // Generator states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_DATA = 4'b0010,
        ST_CRCH = 4'b0100,
        ST_CRCL = 4'b1000
    } dsf_state_t;

endpackage

// *** dsf_stream_if.sv ***
// Byte stream carrier between generator and FIFO
`timescale 1ns/1ps
interface dsf_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    logic       last;

    modport src (output valid, output data, output last, input ready);
    modport snk (input valid, input data, input last, output ready);
endinterface
